// [verilog/pcc_host_pkg.sv]
// Purpose: shared constants, types and helpers for the card memory host port
// Assumes: 16-bit asynchronous strobe bus, one system clock, AHB-Lite status slave
// Notes: store depth is a plain default, not the full register and buffer space
package pcc_host_pkg;
  localparam int HOST_AW = 17;
  localparam int DATA_W = 16;
  localparam int STORE_AW = 8;
  localparam int STRAP_W = 7;
  localparam int HOST_W = 40;

  // endian strap followed by the three bus select straps
  localparam logic [3:0] MODE_GENERIC_LE = 4'h4;
  localparam logic RESERVED_LEVEL = 1'b1;
  // edges after reset release before the synchronised straps are caught
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

  // register bus map, byte offsets of aligned words
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_RDCNT = 8'h08;
  localparam logic [7:0] OFS_WRCNT = 8'h0c;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam int CTRL_PERIOD_LSB = 0;
  localparam int CTRL_LEN_LSB = 8;
  localparam int CTRL_EN_BIT = 16;
  localparam int ST_MODE_LSB = 0;
  localparam int ST_RESERVED_BIT = 4;
  localparam int ST_WAITPOL_BIT = 5;
  localparam int ST_CLKDIV_BIT = 6;
  localparam int ST_MODEOK_BIT = 7;
  localparam int ST_ACTIVE_BIT = 8;
  localparam int ST_REFBUSY_BIT = 9;
  localparam int ST_STICKY_BIT = 10;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef enum logic [2:0] {ST_IDLE, ST_ARB, ST_ACCESS, ST_LOAD, ST_DONE} host_state_t;

  typedef struct packed {
    logic cs_n;
    logic mreg;
    logic hbs_n;
    logic we_n;
    logic rd_n;
    logic bs_n;
    logic rw;
    logic [HOST_AW-1:0] addr;
    logic [DATA_W-1:0] data;
  } host_pins_t;

  typedef struct packed {
    logic clk_div;
    logic wait_pol;
    logic endian;
    logic reserved;
    logic [2:0] sel;
  } straps_t;

  localparam host_pins_t HOST_PINS_IDLE = '{cs_n: 1'b1, mreg: 1'b0, hbs_n: 1'b1,
    we_n: 1'b1, rd_n: 1'b1, bs_n: 1'b1, rw: 1'b1, addr: '0, data: '0};

  typedef struct packed {
    host_state_t fsm;
    logic [1:0] settle;
    logic latched;
    straps_t straps;
    logic tick;
    logic [7:0] ref_cnt;
    logic ref_busy;
    logic [31:0] ctrl;
    logic [15:0] rd_count;
    logic [15:0] wr_count;
    logic sticky;
    logic write;
    logic space;
    logic hbs_n;
    logic [HOST_AW-1:0] addr;
    logic [1:0] lanes;
    logic [DATA_W-1:0] wdata;
    logic req;
    logic [DATA_W-1:0] dout;
    logic oe_n;
    logic hold;
    logic ah_wr;
    logic [7:0] ah_addr;
    logic [31:0] hrdata;
  } core_t;

  // word lanes touched: both for a word, else the lane picked by address bit 0
  function automatic logic [1:0] lanes_of(input logic hbs_n, input logic a0);
    lanes_of = (!hbs_n && !a0) ? 2'h3 : (a0 ? 2'h2 : 2'h1);
  endfunction

  // an odd byte carried on the low pins sits in the high half of the word
  function automatic logic [DATA_W-1:0] steer(input logic hbs_n, input logic a0,
                                              input logic [DATA_W-1:0] d);
    steer = (hbs_n && a0) ? {d[7:0], d[15:8]} : d;
  endfunction
endpackage

// [verilog/pcc_sync.sv]
// Purpose: two-stage synchroniser for a bundle of asynchronous pins
// Assumes: each bit is a level, bundles are sampled only after both stages
// Notes: the first stage feeds the second and nothing else
`timescale 1ns/1ps
module pcc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pins in, settled copy out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] first;
    logic [W-1:0] second;
  } sync_t;

  sync_t st;
  sync_t next_st;

  always_comb begin
    next_st.first = d;
    next_st.second = st.first;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{first: INIT, second: INIT};
    end else begin
      st <= next_st;
    end
  end

  assign q = st.second;
endmodule // pcc_sync

// [verilog/pcc_store.sv]
// Purpose: register and display word store behind the host port
// Assumes: one access per request pulse, read data one cycle later
// Notes: depth is reduced; upper index bits alias
`timescale 1ns/1ps
module pcc_store (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // access request
  input wire logic req,
  input wire logic wr,
  input wire logic space,
  input wire logic [pcc_host_pkg::STORE_AW-1:0] index,
  input wire logic [1:0] lanes,
  input wire logic [pcc_host_pkg::DATA_W-1:0] wdata,
  // read answer
  output logic [pcc_host_pkg::DATA_W-1:0] rdata
);
  typedef struct packed {
    logic [pcc_host_pkg::DATA_W-1:0] rdata;
  } store_t;

  logic [pcc_host_pkg::DATA_W-1:0] mem [0:(2**(pcc_host_pkg::STORE_AW+1))-1];
  store_t st;
  store_t next_st;

  always_comb begin
    next_st = st;
    if (req && !wr) begin
      next_st.rdata = mem[{space, index}];
    end
  end

  // no reset on the array: contents are undefined until software fills them
  always_ff @(posedge clk) begin
    if (req && wr && lanes[0]) begin
      mem[{space, index}][7:0] <= wdata[7:0];
    end
    if (req && wr && lanes[1]) begin
      mem[{space, index}][15:8] <= wdata[15:8];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rdata = st.rdata;
endmodule // pcc_store

// [verilog/pc_card_memory_host_port.sv]
// Purpose: slave end of a 16-bit card memory strobe bus with wait hold-off
// Assumes: CLK_SYS is the free-running bus clock, strobes are asynchronous to it
// Notes: AHB-Lite slave exposes straps, contention control and access counters
//
// Our own choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
module pc_card_memory_host_port (
  // system
  input wire logic CLK_SYS,
  input wire logic RST_N,
  // host strobe bus
  input wire logic CHIP_SELECT_N,
  input wire logic MEM_REG_SELECT,
  input wire logic [pcc_host_pkg::HOST_AW-1:0] HOST_ADDR_IN,
  input wire logic HIGH_BYTE_STROBE_N,
  input wire logic WRITE_STROBE_N,
  input wire logic READ_STROBE_N,
  input wire logic BUS_START_N,
  input wire logic RW_DIRECTION,
  input wire logic [pcc_host_pkg::DATA_W-1:0] HOST_DATA_BUS_IN,
  output logic [pcc_host_pkg::DATA_W-1:0] HOST_DATA_BUS_OUT,
  output logic HOST_DATA_BUS_OE_N,
  output logic HOLD_OFF_N,
  // configuration straps
  input wire logic ENDIAN_STRAP,
  input wire logic [2:0] BUS_SELECT_STRAPS,
  input wire logic RESERVED_STRAP,
  input wire logic WAIT_POLARITY_STRAP,
  input wire logic CLOCK_DIVIDE_STRAP,
  // register bus
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic [31:0] HRDATA,
  output logic HRESP
);
  pcc_host_pkg::core_t st;
  pcc_host_pkg::core_t next_st;
  pcc_host_pkg::host_pins_t host_raw;
  pcc_host_pkg::host_pins_t host_s;
  pcc_host_pkg::straps_t strap_raw;
  pcc_host_pkg::straps_t strap_s;
  logic [pcc_host_pkg::DATA_W-1:0] store_rdata;
  logic mode_ok;
  logic start;
  logic ended;
  logic ahb_take;
  logic hold_pol;

  // pins straight in
  // pins are only bundled here; no logic reads them before the synchroniser
  always_comb begin
    host_raw.cs_n = CHIP_SELECT_N;
    host_raw.mreg = MEM_REG_SELECT;
    host_raw.hbs_n = HIGH_BYTE_STROBE_N;
    host_raw.we_n = WRITE_STROBE_N;
    host_raw.rd_n = READ_STROBE_N;
    host_raw.bs_n = BUS_START_N;
    host_raw.rw = RW_DIRECTION;
    host_raw.addr = HOST_ADDR_IN;
    host_raw.data = HOST_DATA_BUS_IN;
  end

  always_comb begin
    strap_raw.clk_div = CLOCK_DIVIDE_STRAP;
    strap_raw.wait_pol = WAIT_POLARITY_STRAP;
    strap_raw.endian = ENDIAN_STRAP;
    strap_raw.reserved = RESERVED_STRAP;
    strap_raw.sel = BUS_SELECT_STRAPS;
  end

  pcc_sync #(
    .W(pcc_host_pkg::HOST_W),
    .INIT(pcc_host_pkg::HOST_PINS_IDLE)
  ) u_host_sync (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .d(host_raw),
    .q(host_s)
  );

  pcc_sync #(
    .W(pcc_host_pkg::STRAP_W),
    .INIT('0)
  ) u_strap_sync (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .d(strap_raw),
    .q(strap_s)
  );

  // bit 0 only picks the byte lane, so the store is indexed by word
  pcc_store u_store (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .req(st.req),
    .wr(st.write),
    .space(st.space),
    .index(st.addr[pcc_host_pkg::STORE_AW:1]),
    .lanes(st.lanes),
    .wdata(st.wdata),
    .rdata(store_rdata)
  );

  assign mode_ok = st.latched
    && ({st.straps.endian, st.straps.sel} == pcc_host_pkg::MODE_GENERIC_LE)
    && (st.straps.reserved == pcc_host_pkg::RESERVED_LEVEL);

  assign start = !host_s.cs_n && (!host_s.rd_n || !host_s.we_n);
  assign ended = host_s.cs_n || (host_s.rd_n && host_s.we_n);
  // other transfer sizes are left untaken but still answered okay
  assign ahb_take = HSEL && HREADY && HTRANS[1] && (HSIZE == pcc_host_pkg::HSIZE_WORD);

  // refresh counter step; wraps, the compare ends each phase first
  function automatic logic [7:0] step8(input logic [7:0] v);
    step8 = v + 8'h01;
  endfunction

  // access counter step; wraps so software reads a modulo count
  function automatic logic [15:0] step16(input logic [15:0] v);
    step16 = v + 16'h0001;
  endfunction

  // data phase write aimed at one register offset
  function automatic logic wr_hit(input logic wr, input logic [7:0] a, input logic [7:0] ofs);
    wr_hit = wr && (a == ofs);
  endfunction

  always_comb begin
    next_st = st;
    next_st.req = 1'b0;

    // strap capture after release
    // a strap level is read only once it has crossed both synchroniser stages
    if (!st.latched) begin
      if (st.settle == pcc_host_pkg::STRAP_SETTLE) begin
        next_st.latched = 1'b1;
        next_st.straps = strap_s;
      end else begin
        next_st.settle = st.settle + 2'h1;
      end
    end

    next_st.tick = st.straps.clk_div ? ~st.tick : 1'b1;

    // display refresh steals the store for len+1 cycles after each period+1 free cycles
    if (!st.ctrl[pcc_host_pkg::CTRL_EN_BIT]) begin
      next_st.ref_busy = 1'b0;
      next_st.ref_cnt = 8'h00;
    end else if (!st.ref_busy) begin
      if (st.ref_cnt == st.ctrl[pcc_host_pkg::CTRL_PERIOD_LSB +: 8]) begin
        next_st.ref_busy = 1'b1;
        next_st.ref_cnt = 8'h00;
      end else begin
        next_st.ref_cnt = step8(st.ref_cnt);
      end
    end else begin
      if (st.ref_cnt == st.ctrl[pcc_host_pkg::CTRL_LEN_LSB +: 8]) begin
        next_st.ref_busy = 1'b0;
        next_st.ref_cnt = 8'h00;
      end else begin
        next_st.ref_cnt = step8(st.ref_cnt);
      end
    end

    case (st.fsm)
      pcc_host_pkg::ST_IDLE: begin
        if (mode_ok && start) begin
          // write when only write strobe low
          next_st.write = host_s.rd_n && !host_s.we_n;
          next_st.space = host_s.mreg;
          next_st.hbs_n = host_s.hbs_n;
          next_st.addr = host_s.addr;
          next_st.lanes = pcc_host_pkg::lanes_of(host_s.hbs_n, host_s.addr[0]);
          next_st.fsm = pcc_host_pkg::ST_ARB;
        end
      end
      pcc_host_pkg::ST_ARB: begin
        // write data is taken at the grant, a cycle or more after the strobe
        if (st.tick && !st.ref_busy) begin
          next_st.wdata = pcc_host_pkg::steer(st.hbs_n, st.addr[0], host_s.data);
          next_st.req = 1'b1;
          next_st.fsm = pcc_host_pkg::ST_ACCESS;
        end
      end
      pcc_host_pkg::ST_ACCESS: begin
        if (st.write) begin
          next_st.wr_count = step16(st.wr_count);
        end else begin
          next_st.rd_count = step16(st.rd_count);
        end
        next_st.fsm = pcc_host_pkg::ST_LOAD;
      end
      pcc_host_pkg::ST_LOAD: begin
        next_st.dout = pcc_host_pkg::steer(st.hbs_n, st.addr[0], store_rdata);
        next_st.fsm = pcc_host_pkg::ST_DONE;
      end
      pcc_host_pkg::ST_DONE: begin
        if (ended) begin
          next_st.fsm = pcc_host_pkg::ST_IDLE;
        end
      end
      default: begin
        next_st.fsm = pcc_host_pkg::ST_IDLE;
      end
    endcase

    // cycle stretch
    // held from idle so no strobe can slip past before it is synchronised
    next_st.hold = mode_ok && (next_st.fsm != pcc_host_pkg::ST_DONE);

    next_st.oe_n = !((next_st.fsm == pcc_host_pkg::ST_DONE) && !next_st.write
      && !host_s.rd_n && !host_s.cs_n);

    // tied pins watched
    // set wins over a same-cycle software clear
    if (wr_hit(st.ah_wr, st.ah_addr, pcc_host_pkg::OFS_STATUS)
        && HWDATA[pcc_host_pkg::ST_STICKY_BIT]) begin
      next_st.sticky = 1'b0;
    end
    if (mode_ok && (!host_s.bs_n || !host_s.rw)) begin
      next_st.sticky = 1'b1;
    end

    // register bus data phase write
    next_st.ah_wr = ahb_take && HWRITE;
    next_st.ah_addr = HADDR[7:0];
    if (wr_hit(st.ah_wr, st.ah_addr, pcc_host_pkg::OFS_CTRL)) begin
      next_st.ctrl = HWDATA;
    end

    // register bus read, sampled at the address phase
    if (ahb_take && !HWRITE) begin
      case (HADDR[7:0])
        pcc_host_pkg::OFS_CTRL: begin
          next_st.hrdata = st.ctrl;
        end
        pcc_host_pkg::OFS_STATUS: begin
          next_st.hrdata = 32'h0000_0000;
          next_st.hrdata[pcc_host_pkg::ST_MODE_LSB +: 4] = {st.straps.endian, st.straps.sel};
          next_st.hrdata[pcc_host_pkg::ST_RESERVED_BIT] = st.straps.reserved;
          next_st.hrdata[pcc_host_pkg::ST_WAITPOL_BIT] = st.straps.wait_pol;
          next_st.hrdata[pcc_host_pkg::ST_CLKDIV_BIT] = st.straps.clk_div;
          next_st.hrdata[pcc_host_pkg::ST_MODEOK_BIT] = mode_ok;
          next_st.hrdata[pcc_host_pkg::ST_ACTIVE_BIT] = (st.fsm != pcc_host_pkg::ST_IDLE);
          next_st.hrdata[pcc_host_pkg::ST_REFBUSY_BIT] = st.ref_busy;
          next_st.hrdata[pcc_host_pkg::ST_STICKY_BIT] = st.sticky;
        end
        pcc_host_pkg::OFS_RDCNT: begin
          next_st.hrdata = {16'h0000, st.rd_count};
        end
        pcc_host_pkg::OFS_WRCNT: begin
          next_st.hrdata = {16'h0000, st.wr_count};
        end
        default: begin
          next_st.hrdata = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      st <= '0;
      st.fsm <= pcc_host_pkg::ST_IDLE;
      st.ctrl <= pcc_host_pkg::CTRL_RESET;
      st.oe_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // hold-off polarity
  // until the straps are caught the settled strap level sets the idle level
  assign hold_pol = st.latched ? st.straps.wait_pol : strap_s.wait_pol;
  assign HOLD_OFF_N = hold_pol ? st.hold : ~st.hold;
  assign HOST_DATA_BUS_OUT = st.dout;
  assign HOST_DATA_BUS_OE_N = st.oe_n;
  // zero-wait slave, always OKAY
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign HRDATA = st.hrdata;
endmodule // pc_card_memory_host_port

// [sim/host_port_properties.sv]
// Purpose: port checks for the card host port
// Assumes: straps are steady from reset release on
// Notes: age waits out the strap catch after release
`timescale 1ns/1ps
module host_port_properties (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_N,
  // host pins
  input wire logic CHIP_SELECT_N,
  input wire logic READ_STROBE_N,
  input wire logic WRITE_STROBE_N,
  input wire logic [pcc_host_pkg::DATA_W-1:0] HOST_DATA_BUS_OUT,
  input wire logic HOST_DATA_BUS_OE_N,
  input wire logic HOLD_OFF_N,
  // straps and register bus
  input wire logic ENDIAN_STRAP,
  input wire logic [2:0] BUS_SELECT_STRAPS,
  input wire logic RESERVED_STRAP,
  input wire logic WAIT_POLARITY_STRAP,
  input wire logic HREADYOUT,
  input wire logic HRESP
);
  logic [3:0] age;
  logic mode_ok;
  logic rdy;
  logic hold_on;
  logic idle;
  assign mode_ok = {ENDIAN_STRAP, BUS_SELECT_STRAPS} == pcc_host_pkg::MODE_GENERIC_LE
                   && RESERVED_STRAP;
  assign rdy = age == 4'hf && mode_ok;
  assign hold_on = HOLD_OFF_N == WAIT_POLARITY_STRAP;
  assign idle = READ_STROBE_N && WRITE_STROBE_N;
  // straps are caught some edges after release, so wait them out
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      age <= 4'h0;
    end else if (age != 4'hf) begin
      age <= age + 4'h1;
    end
  end
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  bus_okay_a: assert property (HREADYOUT && !HRESP) else $error("bus answer not okay");
  bad_mode_quiet_a: assert property (!mode_ok && age == 4'hf
    |-> !hold_on && HOST_DATA_BUS_OE_N) else $error("port active in wrong mode");
  idle_hold_a: assert property (rdy && idle [*4] |=> hold_on)
    else $error("hold-off not asserted while idle");
  read_wait_a: assert property (rdy && $fell(READ_STROBE_N) |-> hold_on [*4])
    else $error("read answered too early");
  read_answer_a: assert property (rdy && $fell(READ_STROBE_N)
    |-> ##[4:300] (!hold_on && !HOST_DATA_BUS_OE_N)) else $error("read never answered");
  write_answer_a: assert property (rdy && $fell(WRITE_STROBE_N) && READ_STROBE_N
    |-> ##[4:300] (!hold_on && HOST_DATA_BUS_OE_N)) else $error("write never taken");
  done_stays_a: assert property (rdy && !hold_on && !idle |=> !hold_on)
    else $error("hold-off back before strobes rose");
  oe_release_a: assert property (READ_STROBE_N [*4] |=> HOST_DATA_BUS_OE_N)
    else $error("data still driven after read");
  oe_on_read_a: assert property ($fell(HOST_DATA_BUS_OE_N)
    |-> !READ_STROBE_N && !CHIP_SELECT_N) else $error("data driven outside a read");
  data_steady_a: assert property (!HOST_DATA_BUS_OE_N && !$past(HOST_DATA_BUS_OE_N)
    |-> $stable(HOST_DATA_BUS_OUT)) else $error("read data moved while driven");
  cover property (rdy && $fell(READ_STROBE_N));
  cover property (rdy && $fell(WRITE_STROBE_N));
  cover property (!mode_ok && age == 4'hf && !CHIP_SELECT_N);
endmodule // host_port_properties

bind pc_card_memory_host_port host_port_properties props_inst (.CLK_SYS(CLK_SYS),
  .RST_N(RST_N), .CHIP_SELECT_N(CHIP_SELECT_N), .READ_STROBE_N(READ_STROBE_N),
  .WRITE_STROBE_N(WRITE_STROBE_N), .HOST_DATA_BUS_OUT(HOST_DATA_BUS_OUT),
  .HOST_DATA_BUS_OE_N(HOST_DATA_BUS_OE_N), .HOLD_OFF_N(HOLD_OFF_N),
  .ENDIAN_STRAP(ENDIAN_STRAP), .BUS_SELECT_STRAPS(BUS_SELECT_STRAPS),
  .RESERVED_STRAP(RESERVED_STRAP), .WAIT_POLARITY_STRAP(WAIT_POLARITY_STRAP),
  .HREADYOUT(HREADYOUT), .HRESP(HRESP));

// [sim/pcc_socket_model.sv]
// Purpose: card socket host driving the strobe bus
// Assumes: hold-off asserted level equals the polarity strap
// Notes: released address and data lines show the inverse of their last value
`timescale 1ns/1ps
module pcc_socket_model (
  // clock and answer
  input wire logic clk,
  input wire logic pol,
  input wire logic hold_n,
  input wire logic oe_n,
  input wire logic [15:0] dout,
  // strobe bus
  output logic cs_n,
  output logic mreg,
  output logic hbs_n,
  output logic we_n,
  output logic rd_n,
  output logic [16:0] addr,
  output logic [15:0] din
);
  initial begin
    cs_n = 1'b1;
    mreg = 1'b0;
    hbs_n = 1'b1;
    we_n = 1'b1;
    rd_n = 1'b1;
    addr = 17'h0;
    din = 16'h0;
  end
  task automatic xfer(input logic wr, input logic hbs, input logic a17,
                      input logic [16:0] a, input logic [15:0] wd,
                      output logic [15:0] rd, output logic ok);
    int n;
    @(posedge clk);
    cs_n <= 1'b0;
    mreg <= a17;
    addr <= a;
    hbs_n <= hbs;
    din <= wr ? wd : ~din;
    rd_n <= wr;
    we_n <= !wr;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hold_n === pol && n < 400);
    rd = dout;
    ok = n < 400 && (wr || oe_n === 1'b0);
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    we_n <= 1'b1;
    hbs_n <= 1'b1;
    addr <= ~a;
    din <= ~din;
    repeat (4) @(posedge clk);
  endtask
endmodule // pcc_socket_model

// [sim/test_pc_card_memory_host_port.sv]
// Purpose: self-checking bench for the card host port
// Assumes: socket model drives strobes, bench drives the register bus
// Notes: store addresses stay below the aliasing bits
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fails++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module test_pc_card_memory_host_port;
  logic CLK_SYS = 1'b0;
  logic card_reset = 1'b1;
  logic RST_N, cs_n, mreg, hbs_n, we_n, rd_n, oe_n, hold_n, hreadyout, hresp;
  logic [16:0] addr;
  logic [15:0] din, dout, wire_d;
  logic endian = 1'b0, resv = 1'b1, wpol = 1'b0, cdiv = 1'b0, bs_n = 1'b1;
  logic [2:0] sel = 3'h4;
  logic hsel = 1'b0, hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [15:0] mem [int];
  int fails = 0, cmp_count = 0, rd_cnt = 0, wr_cnt = 0;
  always #2 CLK_SYS = ~CLK_SYS;
  // chip reset is the inverted card reset
  assign RST_N = !card_reset;
  // data wire: device drives it when its enable is low
  assign wire_d = oe_n ? din : dout;
  pc_card_memory_host_port pc_card_memory_host_port_inst (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
    .CHIP_SELECT_N(cs_n), .MEM_REG_SELECT(mreg), .HOST_ADDR_IN(addr),
    .HIGH_BYTE_STROBE_N(hbs_n), .WRITE_STROBE_N(we_n), .READ_STROBE_N(rd_n),
    .BUS_START_N(bs_n), .RW_DIRECTION(bs_n), .HOST_DATA_BUS_IN(wire_d),
    .HOST_DATA_BUS_OUT(dout), .HOST_DATA_BUS_OE_N(oe_n), .HOLD_OFF_N(hold_n),
    .ENDIAN_STRAP(endian), .BUS_SELECT_STRAPS(sel), .RESERVED_STRAP(resv),
    .WAIT_POLARITY_STRAP(wpol), .CLOCK_DIVIDE_STRAP(cdiv), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(pcc_host_pkg::HSIZE_WORD), .HWDATA(hwdata),
    .HREADY(hreadyout), .HREADYOUT(hreadyout), .HRDATA(hrdata), .HRESP(hresp));
  pcc_socket_model pcc_socket_model_inst (.clk(CLK_SYS), .pol(wpol), .hold_n(hold_n),
    .oe_n(oe_n), .dout(dout), .cs_n(cs_n), .mreg(mreg), .hbs_n(hbs_n), .we_n(we_n),
    .rd_n(rd_n), .addr(addr), .din(din));
  task automatic wrap_up;
    if (fails == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic wait_ready(inout int n);
    do begin
      @(posedge CLK_SYS);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge CLK_SYS);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    wait_ready(n);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready(n);
    rd = hrdata;
    if (n >= 50) begin
      fails++;
      wrap_up;
    end
  endtask
  task automatic restart(input logic c, input logic w, input logic e);
    @(posedge CLK_SYS);
    card_reset <= 1'b1;
    cdiv <= c;
    wpol <= w;
    endian <= e;
    repeat (4) @(posedge CLK_SYS);
    card_reset <= 1'b0;
    repeat (8) @(posedge CLK_SYS);
    rd_cnt = 0;
    wr_cnt = 0;
  endtask
  task automatic status_chk(input logic st);
    logic [31:0] r;
    ahb(1'b0, pcc_host_pkg::OFS_STATUS, 32'h0, r);
    `CHK(r[10:0], {st, 3'h1, cdiv, wpol, resv, endian, sel})
  endtask
  task automatic count_chk;
    logic [31:0] r;
    ahb(1'b0, pcc_host_pkg::OFS_RDCNT, 32'h0, r);
    `CHK(r, {16'h0, 16'(rd_cnt)})
    ahb(1'b0, pcc_host_pkg::OFS_WRCNT, 32'h0, r);
    `CHK(r, {16'h0, 16'(wr_cnt)})
  endtask
  task automatic traffic(input int cnt);
    logic [15:0] d, r, m, e;
    logic [1:0] md;
    logic ok, wr;
    int j;
    for (int i = 0; i < cnt; i++) begin
      j = (i < 8) ? i : int'($urandom_range(7, 0));
      md = (i < 8) ? 2'h0 : 2'($urandom_range(3, 0));
      wr = (i < 8) ? 1'b1 : 1'($urandom_range(1, 0));
      d = 16'($urandom);
      pcc_socket_model_inst.xfer(wr, md[1], j[0], {8'h00, 8'(j * 37 + 3), md[0]}, d, r, ok);
      `CHK(ok, 1'b1)
      if (!ok) begin
        wrap_up;
      end
      if (wr) begin
        wr_cnt++;
        case (md)
          2'h0: mem[j] = d;
          2'h1: mem[j][15:8] = d[15:8];
          2'h2: mem[j][7:0] = d[7:0];
          default: mem[j][15:8] = d[7:0];
        endcase
      end else begin
        rd_cnt++;
        e = md[1] ? {8'h00, md[0] ? mem[j][15:8] : mem[j][7:0]} : mem[j];
        m = md[1] ? 16'h00ff : (md[0] ? 16'hff00 : 16'hffff);
        `CHK(r & m, e & m)
      end
    end
  endtask
  initial begin
    logic [31:0] r;
    logic [15:0] d;
    logic ok;
    void'($urandom(38362));
    restart(1'b0, 1'b0, 1'b0);
    status_chk(1'b0);
    traffic(40);
    // refresh contention stretches hold-off during traffic
    ahb(1'b1, pcc_host_pkg::OFS_CTRL, 32'h0001_0305, r);
    ahb(1'b0, pcc_host_pkg::OFS_CTRL, 32'h0, r);
    `CHK(r, 32'h0001_0305)
    traffic(40);
    count_chk;
    ahb(1'b1, pcc_host_pkg::OFS_CTRL, 32'h0, r);
    ahb(1'b0, 8'h10, 32'h0, r);
    `CHK(r, 32'h0)
    bs_n <= 1'b0;
    @(posedge CLK_SYS);
    bs_n <= 1'b1;
    // the tied pin crosses two flops and the flag register before it reads back
    repeat (2) @(posedge CLK_SYS);
    ahb(1'b0, pcc_host_pkg::OFS_STATUS, 32'h0, r);
    `CHK(r[10], 1'b1)
    ahb(1'b1, pcc_host_pkg::OFS_STATUS, 32'h0000_0400, r);
    status_chk(1'b0);
    restart(1'b1, 1'b1, 1'b0);
    status_chk(1'b0);
    traffic(24);
    count_chk;
    restart(1'b0, 1'b0, 1'b1);
    repeat (8) @(posedge CLK_SYS);
    pcc_socket_model_inst.xfer(1'b0, 1'b0, 1'b0, 17'h0, 16'h0, d, ok);
    `CHK(ok, 1'b0)
    ahb(1'b0, pcc_host_pkg::OFS_STATUS, 32'h0, r);
    `CHK(r[7], 1'b0)
    wrap_up;
  end
endmodule // test_pc_card_memory_host_port
